// >>> rtl/ext_store_and_subtract_exec.sv
`timescale 1ns/1ps
module ext_store_and_subtract_exec
   import ext_sub_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic issue_valid_in,
   input instr_type instr_in,
   input core_regs_type regs_in,
   output logic issue_ready_out,
   output logic [6:0] ptr_word_addr_out,
   input wire logic [15:0] ptr_word_in,
   output logic [15:0] byte_addr_out,
   input wire logic [7:0] byte_data_in,
   output logic ext_we_out,
   output ext_write_type ext_write_out,
   output logic done_out,
   output logic acc_we_out,
   output logic [7:0] acc_out,
   output logic flags_we_out,
   output sub_flags_type flags_out,
   output logic [15:0] pc_out
);

   exec_state_type state;
   exec_state_type next_state;
   logic is_store;
   logic is_sub_imm;
   logic is_sub_ind;
   logic take;
   logic [5:0] sel;
   logic [15:0] disp;
   logic [5:0] sel_q;
   logic [15:0] disp_q;
   logic is_store_q;
   core_regs_type regs_q;
   logic [15:0] eff_addr;
   logic [7:0] sub_rhs;
   logic [7:0] sub_lhs;
   logic [7:0] sub_diff;
   sub_flags_type sub_flags;
   logic finish_sub;
   logic finish_store;

   // decode; the request is held off unless idle, unknown opcodes are not taken
   assign is_store = instr_in.opcode == OP_STORE_EXT;
   assign is_sub_imm = instr_in.opcode == OP_SUB_IMM;
   assign is_sub_ind = instr_in.opcode == OP_SUB_IND;
   assign issue_ready_out = state == ST_IDLE;
   assign take = issue_valid_in && issue_ready_out && (is_store || is_sub_imm || is_sub_ind);

   // offset form always uses pair reg zero; otherwise bits 6..1 pick 0..63
   assign sel = instr_in.operand[OFFSET_FORM_BIT] ? 6'h00 :
                instr_in.operand[SEL_MSB:SEL_LSB];
   // displacement: signed 7-bit offset, signed C, or none
   assign disp = instr_in.operand[OFFSET_FORM_BIT] ?
                 {{9{instr_in.operand[6]}}, instr_in.operand[6:0]} :
                 instr_in.operand[C_FORM_BIT] ?
                 {{8{regs_in.c[7]}}, regs_in.c} : 16'h0000;

   // pointer word sits at RAM 2n/2n+1; memory answers in the same cycle
   assign ptr_word_addr_out = {sel_q, 1'b0};
   assign eff_addr = ptr_word_in + disp_q;
   assign byte_addr_out = eff_addr;

   // operand is immediate byte at issue, memory byte in the pointer cycle
   assign sub_rhs = (state == ST_IDLE) ? instr_in.operand : byte_data_in;
   assign sub_lhs = (state == ST_IDLE) ? regs_in.acc : regs_q.acc;
   byte_subtractor u_sub (
      .minuend_in(sub_lhs),
      .subtrahend_in(sub_rhs),
      .diff_out(sub_diff),
      .flags_out(sub_flags)
   );

   assign finish_sub = (take && is_sub_imm) || (state == ST_PTR && !is_store_q);
   assign finish_store = state == ST_WRITE;
   assign ext_we_out = state == ST_WRITE;

   // sequence: store walks ptr, hold, write; indirect subtract ends in ptr
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (take && !is_sub_imm) begin
               next_state = ST_PTR;
            end
         end
         ST_PTR: begin
            next_state = is_store_q ? ST_HOLD : ST_IDLE;
         end
         ST_HOLD: begin
            next_state = ST_WRITE;
         end
         ST_WRITE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // operands captured at issue so the core may move on
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sel_q <= 6'h00;
         disp_q <= 16'h0000;
         is_store_q <= 1'b0;
         regs_q <= '0;
      end else if (take) begin
         sel_q <= sel;
         disp_q <= disp;
         is_store_q <= is_store;
         regs_q <= regs_in;
      end
   end

   // store target: 16-bit pointer sum, bank byte B on bits 23-16
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ext_write_out <= '0;
      end else if (state == ST_PTR && is_store_q) begin
         ext_write_out.addr <= {8'h00, eff_addr} + {regs_q.b, 16'h0000};
         ext_write_out.data <= regs_q.acc;
      end
   end

   // results; a store raises done but never the acc or flag write strobes
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         done_out <= 1'b0;
         acc_we_out <= 1'b0;
         flags_we_out <= 1'b0;
         acc_out <= ACC_RESET;
         flags_out <= '0;
         pc_out <= PC_RESET;
      end else begin
         done_out <= finish_sub || finish_store;
         acc_we_out <= finish_sub;
         flags_we_out <= finish_sub;
         if (finish_sub) begin
            acc_out <= sub_diff;
            flags_out <= sub_flags;
            pc_out <= (state == ST_IDLE ? regs_in.pc : regs_q.pc) + PC_STEP;
         end else if (finish_store) begin
            pc_out <= regs_q.pc + PC_STEP;
         end
      end
   end

   // checks
   sequence s_store_walk;
      ##1 (state == ST_PTR) ##1 (state == ST_HOLD) ##1 ext_we_out ##1 done_out;
   endsequence

   sequence s_take_store;
      take && is_store;
   endsequence

   a_store_four_cycles: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      s_take_store |-> s_store_walk)
      else $error("store did not finish in four cycles");

   // the issue cycle may still carry the strobes of an earlier subtract
   a_store_no_flags: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      s_take_store |=> (!flags_we_out && !acc_we_out) [*4])
      else $error("store touched acc or flags");

   a_store_pc_step: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      s_take_store |-> ##4 (pc_out == $past(regs_in.pc, 4) + PC_STEP))
      else $error("store pc not advanced by two");

   a_store_addr_form: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (state == ST_PTR && is_store_q) |=> (ext_write_out.addr ==
         {$past(regs_q.b), $past(ptr_word_in) + $past(disp_q)} &&
         ext_write_out.data == $past(regs_q.acc)))
      else $error("store address or data wrong");

   a_c_sign_extend: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (take && !instr_in.operand[OFFSET_FORM_BIT] && instr_in.operand[C_FORM_BIT])
      |=> (disp_q == {{8{$past(regs_in.c[7])}}, $past(regs_in.c)}))
      else $error("C displacement not sign-extended");

   a_offset_form_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (take && instr_in.operand[OFFSET_FORM_BIT]) |=> (sel_q == 6'h00 &&
         disp_q[15:6] == {10{$past(instr_in.operand[6])}}))
      else $error("offset form used wrong pointer or offset");

   a_sel_field: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (take && !instr_in.operand[OFFSET_FORM_BIT]) |=>
      (ptr_word_addr_out == {$past(instr_in.operand[SEL_MSB:SEL_LSB]), 1'b0}))
      else $error("pair register index wrong");

   a_imm_one_cycle: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (take && is_sub_imm) |=> (done_out && flags_we_out &&
         acc_out == $past(regs_in.acc) - $past(instr_in.operand)))
      else $error("immediate subtract wrong or late");

   a_ind_two_cycles: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (take && is_sub_ind) |=> !done_out ##1 (done_out && acc_we_out && flags_we_out))
      else $error("indirect subtract not two cycles");

   a_carry_borrow: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      finish_sub |=> (flags_out.carry_flag == ($past(sub_rhs) > $past(sub_lhs))))
      else $error("carry not a borrow");

endmodule

// >>> common/ext_sub_pkg.sv
package ext_sub_pkg;

   // opcodes and operand-byte fields
   localparam logic [7:0] OP_STORE_EXT = 8'h91;
   localparam logic [7:0] OP_SUB_IMM = 8'hc1;
   localparam logic [7:0] OP_SUB_IND = 8'hc2;
   localparam int OFFSET_FORM_BIT = 7;
   localparam int C_FORM_BIT = 0;
   localparam int SEL_LSB = 1;
   localparam int SEL_MSB = 6;
   localparam int BANK_LSB = 16;

   // every instruction of this group is two bytes long
   localparam logic [15:0] PC_STEP = 16'h0002;

   // cycles from the taking edge to done_out
   localparam int SUB_IMM_CYCLES = 1;
   localparam int SUB_IND_CYCLES = 2;
   localparam int STORE_CYCLES = 4;

   // reset values
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [15:0] PC_RESET = 16'h0000;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_PTR = 4'b0010,
      ST_HOLD = 4'b0100,
      ST_WRITE = 4'b1000
   } exec_state_type;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] operand;
   } instr_type;

   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] b;
      logic [7:0] c;
      logic [15:0] pc;
   } core_regs_type;

   typedef struct packed {
      logic [23:0] addr;
      logic [7:0] data;
   } ext_write_type;

   typedef struct packed {
      logic carry_flag;
      logic half_carry_flag;
      logic overflow_flag;
   } sub_flags_type;

endpackage

// >>> rtl/byte_subtractor.sv
`timescale 1ns/1ps
// 8-bit subtract with borrow-style flags
module byte_subtractor
   import ext_sub_pkg::*;
(
   input wire logic [7:0] minuend_in,
   input wire logic [7:0] subtrahend_in,
   output logic [7:0] diff_out,
   output sub_flags_type flags_out
);

   logic [8:0] wide_diff;
   logic [4:0] low_diff;

   // borrow out of bit 7 and bit 3; signed overflow from operand and result signs
   assign wide_diff = {1'b0, minuend_in} - {1'b0, subtrahend_in};
   assign low_diff = {1'b0, minuend_in[3:0]} - {1'b0, subtrahend_in[3:0]};
   assign diff_out = wide_diff[7:0];
   assign flags_out.carry_flag = wide_diff[8];
   assign flags_out.half_carry_flag = low_diff[4];
   assign flags_out.overflow_flag = (minuend_in[7] != subtrahend_in[7]) &&
                                    (wide_diff[7] != minuend_in[7]);

endmodule

// >>> verif/ext_mem_model.sv
`timescale 1ns/1ps
// combinational ram stand-in answering pointer and operand reads
module ext_mem_model (
   input wire logic [6:0] ptr_word_addr_in,
   input wire logic [15:0] byte_addr_in,
   output logic [15:0] ptr_word_out,
   output logic [7:0] byte_data_out
);
   logic [7:0] ram [0:511];
   wire logic [8:0] lo_addr = {2'h0, ptr_word_addr_in};
   // low byte at 2n, high byte at 2n+1
   assign ptr_word_out = {ram[lo_addr + 9'h001], ram[lo_addr]};
   // space beyond the array follows the address, so a wrong address cannot match
   assign byte_data_out = (byte_addr_in[15:9] == 7'h00) ? ram[byte_addr_in[8:0]] : ~byte_addr_in[7:0];
   initial begin
      for (int i = 0; i < 512; i++) begin
         ram[i] = 8'h00;
      end
   end
endmodule

// >>> verif/ext_store_and_subtract_exec_test.sv
`timescale 1ns/1ps
module ext_store_and_subtract_exec_test import ext_sub_pkg::*; ;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic valid = 1'b0;
   instr_type instr = '0;
   core_regs_type regs = '0;
   logic ready, ext_we, done, acc_we, flags_we;
   logic [6:0] ptr_a;
   logic [15:0] ptr_w, byte_a, pc;
   logic [7:0] byte_d, acc;
   ext_write_type ext_w;
   sub_flags_type flags;
   int miscompares = 0;
   int cmp_count = 0;
   int cyc, we_at, we_cnt;
   logic [31:0] we_val;
   logic [1:0] we_s;

   ext_store_and_subtract_exec i_ext_store_and_subtract_exec (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .issue_valid_in(valid), .instr_in(instr), .regs_in(regs), .issue_ready_out(ready),
      .ptr_word_addr_out(ptr_a), .ptr_word_in(ptr_w), .byte_addr_out(byte_a), .byte_data_in(byte_d),
      .ext_we_out(ext_we), .ext_write_out(ext_w), .done_out(done), .acc_we_out(acc_we), .acc_out(acc),
      .flags_we_out(flags_we), .flags_out(flags), .pc_out(pc));
   ext_mem_model i_ext_mem_model (.ptr_word_addr_in(ptr_a), .byte_addr_in(byte_a),
      .ptr_word_out(ptr_w), .byte_data_out(byte_d));

   always #5 clk_in = ~clk_in;

   task stop_test;
      $display("errors %0d compares %0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task cmp_data(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: value %h expected %h", $time, got, exp);
      end
   endtask

   task cmp_cycles(input int got, input int exp);
      cmp_count++;
      if (got != exp) begin
         miscompares++;
         $display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask

   // one issue, then watch each cycle until done, noting any external write
   task run(input logic [7:0] op, opd, a, b, c);
      @(posedge clk_in);
      valid <= 1'b1;
      instr <= '{op, opd};
      regs <= '{a, b, c, {opd, a}};
      @(posedge clk_in);
      valid <= 1'b0;
      we_cnt = 0;
      we_at = 0;
      cyc = 0;
      for (int j = 1; j < 20 && cyc == 0; j++) begin
         #1;
         if (ext_we === 1'b1) begin
            we_cnt++;
            we_at = j;
            we_val = ext_w;
         end
         if (done === 1'b1) begin
            cyc = j;
            we_s = {acc_we, flags_we};
         end else begin
            @(posedge clk_in);
         end
      end
   endtask

   task sb(input logic [7:0] op, opd, c, a, ea, input logic [2:0] ef, input int ec);
      run(op, opd, a, 8'h00, c);
      cmp_cycles(cyc, ec);
      cmp_data(acc, ea);
      cmp_data(flags, ef);
      cmp_data(we_s, 2'b11);
      cmp_data(pc, {opd, a} + PC_STEP);
   endtask

   task st(input logic [7:0] opd, c, input logic [23:0] ea);
      run(OP_STORE_EXT, opd, 8'hfd, 8'h20, c);
      cmp_cycles(cyc, STORE_CYCLES);
      cmp_cycles(we_cnt * 8 + we_at, 8 + STORE_CYCLES - 1);
      cmp_data(we_val, {ea, 8'hfd});
      cmp_data(we_s, 2'b00);
      cmp_data(pc, {opd, 8'hfd} + PC_STEP);
   endtask

   task sub_scn;
      i_ext_mem_model.ram[2] = 8'h55;
      i_ext_mem_model.ram[8'h55] = 8'h55;
      i_ext_mem_model.ram[8'h59] = 8'h55;
      i_ext_mem_model.ram[126] = 8'h80;
      i_ext_mem_model.ram[8'h80] = 8'h10;
      i_ext_mem_model.ram[8'h3f] = 8'h2a;
      sb(OP_SUB_IMM, 8'h13, 8'h00, 8'h55, 8'h42, 3'b000, SUB_IMM_CYCLES);
      sb(OP_SUB_IMM, 8'h03, 8'h00, 8'h42, 8'h3f, 3'b010, SUB_IMM_CYCLES);
      sb(OP_SUB_IMM, 8'h02, 8'h00, 8'h00, 8'hfe, 3'b110, SUB_IMM_CYCLES);
      sb(OP_SUB_IMM, 8'h01, 8'h00, 8'h80, 8'h7f, 3'b011, SUB_IMM_CYCLES);
      sb(OP_SUB_IND, 8'h02, 8'h00, 8'h00, 8'hab, 3'b110, SUB_IND_CYCLES);
      sb(OP_SUB_IND, 8'h02, 8'h00, 8'hab, 8'h56, 3'b001, SUB_IND_CYCLES);
      sb(OP_SUB_IND, 8'h03, 8'h04, 8'h56, 8'h01, 3'b000, SUB_IND_CYCLES);
      sb(OP_SUB_IND, 8'h7e, 8'h00, 8'h08, 8'hf8, 3'b100, SUB_IND_CYCLES);
      // offset form of the indirect subtract: pair reg zero is still 0000 here
      sb(OP_SUB_IND, 8'hbf, 8'h00, 8'h55, 8'h2b, 3'b010, SUB_IND_CYCLES);
   endtask

   task store_scn;
      i_ext_mem_model.ram[1] = 8'h01;
      i_ext_mem_model.ram[5] = 8'h01;
      st(8'h05, 8'h3f, 24'h20013f);
      st(8'h05, 8'hc0, 24'h2000c0);
      st(8'hbf, 8'h00, 24'h20013f);
      st(8'hc0, 8'h00, 24'h2000c0);
      st(8'h7f, 8'h80, 24'h200000);
   endtask

   // a foreign opcode must never be taken
   task refuse_scn;
      @(posedge clk_in);
      valid <= 1'b1;
      instr <= '{8'h00, 8'h05};
      repeat (6) @(posedge clk_in);
      #1;
      cmp_data({done, ext_we, acc_we, flags_we, ready, pc}, {5'b00001, 16'h7fff});
      @(posedge clk_in);
      valid <= 1'b0;
   endtask

   initial begin
      repeat (8) @(posedge clk_in);
      rst_b_in <= 1'b1;
      sub_scn();
      store_scn();
      refuse_scn();
      stop_test();
   end

   // the whole run needs well under 200 cycles
   initial begin
      #20000;
      miscompares++;
      stop_test();
   end
endmodule
